// ### rtl/fcd_port.sv
// flexible converter data port: pin mapping, channel markers, buffered clocks
//
// Operation
// - full-duplex mode selectable by strap pin or by serial control register
// - only full-duplex runs receive and transmit together; others one direction
// - full-duplex: upper bus is interleaved transmit input
// - full-duplex: lower bus outputs interleaved receive samples
// - full-duplex: receive and transmit each put to sleep by own pin
// - full-duplex allows only 2x or 4x interpolation, by pin or register
// - transmit marker high routes word to channel A, low to channel B
// - full-duplex: pin c gives one rising edge per transmit word
// - programmable divider sets ADC rate, capped at grade maximum
// - full-duplex receive words leave at twice the sample rate
// - pin config full-duplex: channel A while pin b low, B while high
// - pin config full-duplex: pin a marker in, b receive clock, c transmit clock
// - narrow half duplex: one bus data, other bus MSB marker, rest three-state
// - wide half duplex: both buses carry A and B in parallel
// - legacy mode reachable only through the serial control register
// - legacy receive: A on lower, B on upper, at sample rate
// - legacy transmit: upper interleaved input, lower MSB marker, rest three-state
// - serial config: pin b outputs system clock in full duplex, optional otherwise
// - strap pins caught at reset release and held afterwards
// - narrow half duplex receive: A with marker low, B with marker high
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

// one sample period is four divider ticks, one quarter each:
//   quarter 0: receive word A leaves, transmit clock high, both ADC samples taken
//   quarter 1: word A holds, transmit clock low
//   quarter 2: receive word B leaves, transmit clock high
//   quarter 3: word B holds, transmit clock low
// transmit words close on entry to quarters 0 and 2; the back end must keep each word
// steady for three cycles past that edge, two synchroniser stages plus the capture

module fcd_port #(
  parameter int ADC_GRADE_HZ = fcd_pkg::ADC_MAX_HZ_FAST
) (
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire logic [1:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  // straps and sleep pins
  input wire logic fdSelPin,
  input wire logic interp4Pin,
  input wire logic rx_sleep_pin,
  input wire logic tx_sleep_pin,
  // upper and lower data buses
  input wire logic [9:0] upper_data_bus_in,
  output logic [9:0] upper_data_bus_out,
  output logic [9:0] upper_data_bus_oe_n,
  input wire logic [9:0] lower_data_bus_in,
  output logic [9:0] lower_data_bus_out,
  output logic [9:0] lower_data_bus_oe_n,
  // interface control pins
  input wire logic flex_ctrl_pin_a_in,
  output logic flex_ctrl_pin_a_out,
  output logic flex_ctrl_pin_a_oe_n,
  input wire logic flex_ctrl_pin_b_in,
  output logic flex_ctrl_pin_b_out,
  output logic flex_ctrl_pin_b_oe_n,
  input wire logic flex_ctrl_pin_c_in,
  output logic flex_ctrl_pin_c_out,
  output logic flex_ctrl_pin_c_oe_n,
  // converter side
  input wire logic [9:0] adcDataA,
  input wire logic [9:0] adcDataB,
  output logic adcSampleEn,
  output logic [9:0] dacDataA,
  output logic [9:0] dacDataB,
  output logic dacValidA,
  output logic dacValidB,
  output logic [1:0] dacInterp
);

  // least divider value that keeps the ADC within its grade
  localparam int MIN_DIV_INT = (fcd_pkg::CLK_HZ + fcd_pkg::TICKS_PER_SAMPLE * ADC_GRADE_HZ - 1)
                             / (fcd_pkg::TICKS_PER_SAMPLE * ADC_GRADE_HZ) - 1;
  localparam logic [7:0] MIN_DIV = 8'(MIN_DIV_INT);

  initial begin
    if (ADC_GRADE_HZ != fcd_pkg::ADC_MAX_HZ_SLOW && ADC_GRADE_HZ != fcd_pkg::ADC_MAX_HZ_FAST) begin
      $error("fcd_port: unsupported ADC grade");
    end
    if (MIN_DIV_INT > 255) begin
      $error("fcd_port: divider cannot reach ADC grade");
    end
    if (fcd_pkg::TICKS_PER_SAMPLE != 4) begin
      $error("fcd_port: quarter counter serves four ticks per sample only");
    end
  end

  fcd_pkg::fcd_state_t s_q;
  fcd_pkg::fcd_state_t s_d;

  // decoded configuration
  fcd_pkg::fcd_mode_t mode;
  fcd_pkg::fcd_interp_t interpReq;
  fcd_pkg::fcd_interp_t interpEff;
  logic serialCfg;
  logic dirTx;
  logic rxOn;
  logic txOn;

  // divider and phase
  logic tick;
  logic [1:0] quarterNext;
  logic [7:0] divEff;
  logic wordEnd;
  logic sampleStart;

  // words and clocks seen at the pins
  logic txMarker;
  logic [9:0] txWord;
  logic rxClk;
  logic rxClkWide;
  logic txClk;
  logic [9:0] rxWord;
  logic [9:0] markerBus;

  always_comb begin
    s_d = s_q;
    // pins cross into the clock domain through two flops
    s_d.meta.upper = upper_data_bus_in;
    s_d.meta.lower = lower_data_bus_in;
    s_d.meta.pinA = flex_ctrl_pin_a_in;
    s_d.meta.pinB = flex_ctrl_pin_b_in;
    s_d.meta.fdSel = fdSelPin;
    s_d.meta.interp4Sel = interp4Pin;
    s_d.meta.rxSleep = rx_sleep_pin;
    s_d.meta.txSleep = tx_sleep_pin;
    s_d.sync = s_q.meta;
    s_d.inReset = 1'b0;

    // straps caught on the first cycle after release, then frozen
    // the synchronisers run through reset, so that cycle sees settled strap levels
    if (s_q.inReset) begin
      s_d.strapFd = s_q.sync.fdSel;
      s_d.strapNarrow = s_q.sync.pinB;
      s_d.strapInterp4 = s_q.sync.interp4Sel;
    end

    // effective mode: legacy only exists behind the serial control bit
    // pin b serves as width strap only while pin config is in force
    serialCfg = s_q.ctrl[fcd_pkg::CTRL_SERIAL_BIT];
    if (serialCfg) begin
      mode = fcd_pkg::fcd_mode_t'(s_q.ctrl[fcd_pkg::CTRL_MODE_LSB +: 2]);
      interpReq = fcd_pkg::fcd_interp_t'(s_q.ctrl[fcd_pkg::CTRL_INTERP_LSB +: 2]);
    end else if (s_q.strapFd) begin
      mode = fcd_pkg::FULL_DUPLEX_MODE;
      interpReq = s_q.strapInterp4 ? fcd_pkg::INTERP_4X : fcd_pkg::INTERP_2X;
    end else begin
      mode = s_q.strapNarrow ? fcd_pkg::HALF_DUPLEX_NARROW_MODE
                             : fcd_pkg::HALF_DUPLEX_WIDE_MODE;
      interpReq = s_q.strapInterp4 ? fcd_pkg::INTERP_4X : fcd_pkg::INTERP_2X;
    end

    // only the wide mode may bypass interpolation
    // a reserved interpolation code falls back to 2x rather than stalling the DAC
    case (interpReq)
      fcd_pkg::INTERP_4X: interpEff = fcd_pkg::INTERP_4X;
      fcd_pkg::INTERP_1X: interpEff = (mode == fcd_pkg::HALF_DUPLEX_WIDE_MODE)
                                      ? fcd_pkg::INTERP_1X : fcd_pkg::INTERP_2X;
      default: interpEff = fcd_pkg::INTERP_2X;
    endcase
    s_d.dacInterp = interpEff;

    // direction and sleep: full duplex keeps both paths, others just one
    // direction follows pin a live, so a turn in mid word can cut that word short
    // a stopped path also stops its clock pin, so the back end sees a quiet line
    dirTx = s_q.sync.pinA;
    rxOn = !s_q.sync.rxSleep && (mode == fcd_pkg::FULL_DUPLEX_MODE || !dirTx);
    txOn = !s_q.sync.txSleep && (mode == fcd_pkg::FULL_DUPLEX_MODE || dirTx);

    // divider: one tick per quarter of a sample period, clamped to the grade
    // a divider value below the grade floor is raised silently, never refused
    divEff = (s_q.adcDiv < MIN_DIV) ? MIN_DIV : s_q.adcDiv;
    tick = (s_q.tickCnt >= divEff);
    s_d.tickCnt = tick ? 8'h00 : s_q.tickCnt + 8'h01;
    quarterNext = tick ? s_q.quarter + 2'h1 : s_q.quarter;
    s_d.quarter = quarterNext;
    wordEnd = tick && quarterNext[0] == 1'b0; // a word closes at quarter 0 and 2
    sampleStart = tick && quarterNext == 2'h0;
    s_d.adcSampleEn = sampleStart && rxOn;
    // system clock output at half the port clock, the fastest a flop can toggle
    s_d.sysTgl = !s_q.sysTgl;

    // both channels latched together at the sample instant
    // held apart from the live inputs so a pair never mixes two instants
    if (sampleStart) begin
      s_d.holdA = adcDataA;
      s_d.holdB = adcDataB;
    end

    // buffered clocks built from the quarter phase
    rxClk = quarterNext[1]; // low across the A word, high across the B word
    rxClkWide = !quarterNext[1]; // one rise per sample for parallel receive
    txClk = !quarterNext[0];
    rxWord = quarterNext[1] ? s_d.holdB : s_d.holdA;
    markerBus = {quarterNext[1], 9'h000};

    // transmit capture on word close; marker comes with the word
    // capture reads the synchronised pins, hence the three-cycle hold on the back end
    txMarker = (mode == fcd_pkg::FULL_DUPLEX_MODE) ? s_q.sync.pinA : s_q.sync.lower[9];
    txWord = s_q.sync.upper;
    s_d.dacValidA = 1'b0;
    s_d.dacValidB = 1'b0;
    if (txOn && wordEnd) begin
      if (mode == fcd_pkg::HALF_DUPLEX_WIDE_MODE) begin
        // wide transmit takes both words once per sample, at the quarter 0 edge
        if (quarterNext == 2'h0) begin
          s_d.dacA = s_q.sync.upper;
          s_d.dacB = s_q.sync.lower;
          s_d.dacValidA = 1'b1;
          s_d.dacValidB = 1'b1;
        end
      end else if (txMarker) begin
        s_d.dacA = txWord;
        s_d.dacValidA = 1'b1;
      end else begin
        s_d.dacB = txWord;
        s_d.dacValidB = 1'b1;
      end
    end

    // default pin state: buses, pin a and pin b released, pin c driven low
    s_d.upperOut = 10'h000;
    s_d.upperOeN = 10'h3FF;
    s_d.lowerOut = 10'h000;
    s_d.lowerOeN = 10'h3FF;
    s_d.pinAOut = 1'b0;
    s_d.pinAOeN = 1'b1; // pin a is always marker or direction input
    s_d.pinBOut = 1'b0;
    s_d.pinBOeN = 1'b1;
    s_d.pinCOut = 1'b0;
    s_d.pinCOeN = 1'b0;

    // pin map per mode, direction from pin a outside full duplex:
    //   full duplex: upper in, lower out, pin b receive or system clock, pin c transmit clock
    //   narrow: one bus carries data, the other bus MSB the marker, rest released
    //   wide: both buses carry A and B side by side, pin c one rise per sample
    //   legacy: receive as wide, transmit as narrow
    case (mode)
      fcd_pkg::FULL_DUPLEX_MODE: begin
        s_d.lowerOut = rxWord;
        s_d.lowerOeN = 10'h000;
        s_d.pinBOeN = 1'b0;
        s_d.pinBOut = serialCfg ? s_q.sysTgl : (rxOn && rxClk);
        s_d.pinCOut = txOn && txClk;
      end
      fcd_pkg::HALF_DUPLEX_NARROW_MODE: begin
        if (dirTx) begin
          s_d.pinCOut = txOn && txClk;
        end else begin
          s_d.lowerOut = rxWord;
          s_d.lowerOeN = 10'h000;
          s_d.upperOut = markerBus;
          s_d.upperOeN = 10'h1FF;
          s_d.pinCOut = rxOn && txClk; // one rise per receive word
        end
      end
      fcd_pkg::HALF_DUPLEX_WIDE_MODE: begin
        if (dirTx) begin
          s_d.pinCOut = txOn && rxClkWide;
        end else begin
          s_d.lowerOut = s_d.holdA;
          s_d.upperOut = s_d.holdB;
          s_d.lowerOeN = 10'h000;
          s_d.upperOeN = 10'h000;
          s_d.pinCOut = rxOn && rxClkWide;
        end
      end
      fcd_pkg::LEGACY_MODE: begin
        if (dirTx) begin
          s_d.pinCOut = txOn && txClk;
        end else begin
          s_d.lowerOut = s_d.holdA;
          s_d.upperOut = s_d.holdB;
          s_d.lowerOeN = 10'h000;
          s_d.upperOeN = 10'h000;
          s_d.pinCOut = rxOn && rxClkWide;
        end
      end
      default: begin
        s_d.pinCOut = 1'b0;
      end
    endcase

    // pin b in half duplex: width strap input, or system clock when chosen
    if (mode != fcd_pkg::FULL_DUPLEX_MODE && serialCfg
        && s_q.ctrl[fcd_pkg::CTRL_SYSCLK_HD_BIT]) begin
      s_d.pinBOeN = 1'b0;
      s_d.pinBOut = s_q.sysTgl;
    end

    // register writes
    // a new divider value applies at once; a running count above it ends next cycle
    if (regWrite) begin
      case (regAddr)
        fcd_pkg::ADDR_CTRL: s_d.ctrl = regWrData;
        fcd_pkg::ADDR_DIV: s_d.adcDiv = regWrData[7:0];
        default: s_d.ctrl = s_q.ctrl; // status and unmapped ignore writes
      endcase
    end

    // read data stands only in the cycle after the strobe
    // status shows the decoded mode and interpolation, not the raw request
    s_d.rdData = 16'h0000;
    if (regRead) begin
      case (regAddr)
        fcd_pkg::ADDR_CTRL: s_d.rdData = s_q.ctrl;
        fcd_pkg::ADDR_DIV: s_d.rdData = {8'h00, s_q.adcDiv};
        fcd_pkg::ADDR_STATUS: begin
          s_d.rdData[fcd_pkg::STAT_MODE_LSB +: 2] = mode;
          s_d.rdData[fcd_pkg::STAT_DIR_TX_BIT] = dirTx;
          s_d.rdData[fcd_pkg::STAT_RX_SLEEP_BIT] = s_q.sync.rxSleep;
          s_d.rdData[fcd_pkg::STAT_TX_SLEEP_BIT] = s_q.sync.txSleep;
          s_d.rdData[fcd_pkg::STAT_INTERP_LSB +: 2] = interpEff;
          s_d.rdData[fcd_pkg::STAT_SERIAL_BIT] = serialCfg;
        end
        default: s_d.rdData = 16'h0000;
      endcase
    end
  end

  // single state register; reset leaves all buses released
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q <= '0;
      s_q.inReset <= 1'b1;
      s_q.ctrl <= fcd_pkg::CTRL_RESET;
      s_q.adcDiv <= fcd_pkg::DIV_RESET;
      s_q.upperOeN <= 10'h3FF;
      s_q.lowerOeN <= 10'h3FF;
      s_q.pinAOeN <= 1'b1;
      s_q.pinBOeN <= 1'b1;
      s_q.pinCOeN <= 1'b1;
      s_q.dacInterp <= fcd_pkg::INTERP_2X;
      // synchronisers keep running so the straps are settled at release
      s_q.meta <= s_d.meta;
      s_q.sync <= s_d.sync;
    end else begin
      s_q <= s_d;
    end
  end

  // the caller's flex_ctrl_pin_c_in is never read: pin c only drives
  assign regRdData = s_q.rdData;
  assign upper_data_bus_out = s_q.upperOut;
  assign upper_data_bus_oe_n = s_q.upperOeN;
  assign lower_data_bus_out = s_q.lowerOut;
  assign lower_data_bus_oe_n = s_q.lowerOeN;
  assign flex_ctrl_pin_a_out = s_q.pinAOut;
  assign flex_ctrl_pin_a_oe_n = s_q.pinAOeN;
  assign flex_ctrl_pin_b_out = s_q.pinBOut;
  assign flex_ctrl_pin_b_oe_n = s_q.pinBOeN;
  assign flex_ctrl_pin_c_out = s_q.pinCOut;
  assign flex_ctrl_pin_c_oe_n = s_q.pinCOeN;

  // converter side outputs
  assign adcSampleEn = s_q.adcSampleEn;
  assign dacDataA = s_q.dacA;
  assign dacDataB = s_q.dacB;
  assign dacValidA = s_q.dacValidA;
  assign dacValidB = s_q.dacValidB;
  assign dacInterp = s_q.dacInterp;

endmodule

// ### rtl/fcd_pkg.sv
// constants, enumerations and state layout of the flexible converter data port
package fcd_pkg;

  // system clock and converter rate limits
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int ADC_MAX_HZ_SLOW = 50_000_000;
  localparam int ADC_MAX_HZ_FAST = 80_000_000;
  localparam int DAC_MAX_HZ = 200_000_000;
  localparam int TX_MAX_CH_HZ = 80_000_000;
  // divider ticks per ADC sample instant: two words, each with a high and a low half
  localparam int TICKS_PER_SAMPLE = 4;

  // register indices on the plain register port
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_DIV = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;

  // control register fields
  localparam int CTRL_SERIAL_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_INTERP_LSB = 3;
  localparam int CTRL_SYSCLK_HD_BIT = 5;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [7:0] DIV_RESET = 8'h00;

  // status register fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_DIR_TX_BIT = 2;
  localparam int STAT_RX_SLEEP_BIT = 3;
  localparam int STAT_TX_SLEEP_BIT = 4;
  localparam int STAT_INTERP_LSB = 5;
  localparam int STAT_SERIAL_BIT = 7;

  typedef enum logic [1:0] {
    FULL_DUPLEX_MODE,
    HALF_DUPLEX_NARROW_MODE,
    HALF_DUPLEX_WIDE_MODE,
    LEGACY_MODE
  } fcd_mode_t;

  typedef enum logic [1:0] {
    INTERP_1X,
    INTERP_2X,
    INTERP_4X,
    INTERP_RSVD
  } fcd_interp_t;

  // pins that arrive from outside the clock domain
  typedef struct packed {
    logic [9:0] upper;
    logic [9:0] lower;
    logic pinA;
    logic pinB;
    logic fdSel;
    logic interp4Sel;
    logic rxSleep;
    logic txSleep;
  } fcd_pins_t;

  typedef struct packed {
    fcd_pins_t meta;
    fcd_pins_t sync;
    logic inReset;
    logic strapFd;
    logic strapNarrow;
    logic strapInterp4;
    logic [15:0] ctrl;
    logic [7:0] adcDiv;
    logic [7:0] tickCnt;
    logic [1:0] quarter;
    logic sysTgl;
    logic [9:0] holdA;
    logic [9:0] holdB;
    logic [9:0] upperOut;
    logic [9:0] upperOeN;
    logic [9:0] lowerOut;
    logic [9:0] lowerOeN;
    logic pinAOut;
    logic pinAOeN;
    logic pinBOut;
    logic pinBOeN;
    logic pinCOut;
    logic pinCOeN;
    logic [9:0] dacA;
    logic [9:0] dacB;
    logic dacValidA;
    logic dacValidB;
    fcd_interp_t dacInterp;
    logic adcSampleEn;
    logic [15:0] rdData;
  } fcd_state_t;

endpackage

// ### tb/fcd_port_props.sv
// concurrent checks on the ports of the flexible converter data port
`timescale 1ns/1ps
module fcd_port_props (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic regRead,
  input wire logic [15:0] regRdData,
  input wire logic rx_sleep_pin,
  input wire logic tx_sleep_pin,
  input wire logic flex_ctrl_pin_a_out,
  input wire logic flex_ctrl_pin_a_oe_n,
  input wire logic flex_ctrl_pin_c_oe_n,
  input wire logic adcSampleEn,
  input wire logic [9:0] dacDataA,
  input wire logic dacValidA,
  input wire logic dacValidB,
  input wire logic [1:0] dacInterp
);
  // one domain, so clock and reset are given once
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_pin_a_input: assert property (flex_ctrl_pin_a_oe_n && !flex_ctrl_pin_a_out)
    else $error("pin a is driven by the port");
  chk_pin_c_drive: assert property (!$past(reset) |-> !flex_ctrl_pin_c_oe_n)
    else $error("pin c not driven after reset");
  chk_read_idle: assert property (!regRead |=> regRdData == 16'h0000)
    else $error("read data outside its cycle");
  chk_sample_gap: assert property (adcSampleEn |=> !adcSampleEn [*3])
    else $error("sample instants closer than four ticks");
  // sleep reaches the outputs through two sync flops, margin for a capture stage
  chk_rx_asleep: assert property (rx_sleep_pin [*6] |-> !adcSampleEn)
    else $error("sampling while receive asleep");
  chk_tx_asleep: assert property (tx_sleep_pin [*6] |-> !dacValidA && !dacValidB)
    else $error("dac update while transmit asleep");
  chk_dac_a_pulse: assert property (dacValidA |=> !dacValidA)
    else $error("channel a update longer than one cycle");
  chk_dac_b_pulse: assert property (dacValidB |=> !dacValidB)
    else $error("channel b update longer than one cycle");
  chk_dac_a_hold: assert property (!dacValidA |-> $stable(dacDataA))
    else $error("channel a data moved without update");
  chk_interp_code: assert property (dacInterp != 2'h3)
    else $error("reserved interpolation code");
endmodule

bind fcd_port fcd_port_props u_props (.clk_sys, .reset, .regRead, .regRdData, .rx_sleep_pin,
  .tx_sleep_pin, .flex_ctrl_pin_a_out, .flex_ctrl_pin_a_oe_n, .flex_ctrl_pin_c_oe_n,
  .adcSampleEn, .dacDataA, .dacValidA, .dacValidB, .dacInterp);

// ### tb/fcd_backend.sv
// back-end model: interleaved transmit words with a channel marker
`timescale 1ns/1ps
module fcd_backend (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pinC,
  output logic [9:0] word,
  output logic mark
);
  logic cPrev_q = 1'b0;
  int cnt_q = 0;
  initial word = 10'h2A5;
  initial mark = 1'b1;

  // next word three cycles after each clock rise, so the port has taken the old one
  always @(posedge clk_sys) begin
    cPrev_q <= pinC;
    if (reset) cnt_q <= 0;
    else if (pinC && !cPrev_q) cnt_q <= 3;
    else if (cnt_q != 0) cnt_q <= cnt_q - 1;
    if (cnt_q == 1) begin
      mark <= !mark;
      word <= word * 10'h00D + 10'h101;
    end
  end
endmodule

// ### tb/testbench.sv
// self-checking bench of the flexible converter data port
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [1:0] regAddr = 2'h0;
  logic [15:0] regWrData = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [15:0] regRdData;
  logic fdSel = 1'b1, interp4 = 1'b1, rxSleep = 1'b0, txSleep = 1'b0;
  logic dirTx = 1'b0, fdMark = 1'b1, rxChk = 1'b0, txChk = 1'b0, wide = 1'b0;
  logic [9:0] upOut, upOeN, loOut, loOeN, upIn, loIn, dacA, dacB, pWord, loPrev;
  logic [9:0] adcA = 10'h000, adcB = 10'h000;
  logic aIn, bIn, bOut, bOeN, cIn, cOut, cOeN, vA, vB, sEn, pMark, bPrev, cPrev;
  logic [1:0] interp;
  logic [31:0] rng = 32'h0000123D;
  logic [19:0] pairs[$];
  int num_errors = 0, samples_checked = 0;
  int cyc = 0, nSmp = 0, nRise = 0, nDac = 0, nTgl = 0, s0, r0, d0, t0;

  // resolved pin levels: released upper lines show the back-end word, released lower lines the marker over nine ones
  assign upIn = (~upOeN & upOut) | (upOeN & pWord);
  assign loIn = (~loOeN & loOut) | (loOeN & {pMark, ~loOut[8:0]});
  assign aIn = fdMark ? pMark : dirTx;
  assign bIn = bOeN ? 1'b0 : bOut;
  assign cIn = cOeN ? 1'b0 : cOut;

  fcd_port u_dut (.clk_sys, .reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .fdSelPin(fdSel), .interp4Pin(interp4), .rx_sleep_pin(rxSleep), .tx_sleep_pin(txSleep),
    .upper_data_bus_in(upIn), .upper_data_bus_out(upOut), .upper_data_bus_oe_n(upOeN),
    .lower_data_bus_in(loIn), .lower_data_bus_out(loOut), .lower_data_bus_oe_n(loOeN),
    .flex_ctrl_pin_a_in(aIn), .flex_ctrl_pin_a_out(), .flex_ctrl_pin_a_oe_n(),
    .flex_ctrl_pin_b_in(bIn), .flex_ctrl_pin_b_out(bOut), .flex_ctrl_pin_b_oe_n(bOeN),
    .flex_ctrl_pin_c_in(cIn), .flex_ctrl_pin_c_out(cOut), .flex_ctrl_pin_c_oe_n(cOeN),
    .adcDataA(adcA), .adcDataB(adcB), .adcSampleEn(sEn), .dacDataA(dacA), .dacDataB(dacB),
    .dacValidA(vA), .dacValidB(vB), .dacInterp(interp));
  fcd_backend u_be (.clk_sys, .reset, .pinC(cIn), .word(pWord), .mark(pMark));

  always #12.5 clk_sys = ~clk_sys;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdChk(input logic [1:0] a, input logic [15:0] mask, input logic [15:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(posedge clk_sys);
    check(regRdData & mask, exp);
  endtask

  task automatic mark();
    s0 = nSmp;
    r0 = nRise;
    d0 = nDac;
    t0 = nTgl;
  endtask

  // monitor: counts, transmit routing, receive pairs against the sample queue
  always @(posedge clk_sys) begin
    cyc++;
    nSmp += sEn;
    nRise += (cOut && !cPrev);
    nDac += vA + vB;
    nTgl += (bOut != bPrev);
    if (txChk && !wide && vA) check({5'h00, 1'b1, dacA}, {5'h00, pMark, pWord});
    if (txChk && !wide && vB) check({5'h00, 1'b0, dacB}, {5'h00, pMark, pWord});
    if (txChk && wide && vA) check({6'h00, dacA}, {6'h00, pWord});
    if (txChk && wide && vB) check({6'h00, dacB}, {6'h00, pMark, 9'h1FF});
    if (rxChk && bOut && !bPrev) begin
      check({6'h00, loOut}, {6'h00, pairs[0][9:0]});
      check({6'h00, loPrev}, {6'h00, pairs[0][19:10]});
      void'(pairs.pop_front());
      rng = xs(rng);
      adcA <= rng[9:0];
      adcB <= rng[25:16];
      pairs.push_back({rng[9:0], rng[25:16]});
    end
    bPrev = bOut;
    cPrev = cOut;
    loPrev = loOut;
  end

  // hang guard, far above the roughly 710 cycles the sequence needs
  always @(posedge clk_sys) begin
    if (cyc > 6000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    pairs.push_back(20'h00000);
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    fdSel <= 1'b0;
    interp4 <= 1'b0;
    rdChk(fcd_pkg::ADDR_CTRL, 16'hFFFF, fcd_pkg::CTRL_RESET);
    rdChk(fcd_pkg::ADDR_DIV, 16'hFFFF, {8'h00, fcd_pkg::DIV_RESET});
    rdChk(2'h3, 16'hFFFF, 16'h0000);
    wr(fcd_pkg::ADDR_DIV, 16'h0003);
    wr(fcd_pkg::ADDR_STATUS, 16'hFFFF);
    rdChk(fcd_pkg::ADDR_DIV, 16'h00FF, 16'h0003);
    rdChk(fcd_pkg::ADDR_STATUS, 16'h00E3, 16'h0040);
    check({14'h0, interp}, 16'h0002);
    rxChk <= 1'b1;
    txChk <= 1'b1;
    repeat (40) @(posedge clk_sys);
    mark();
    repeat (160) @(posedge clk_sys);
    check(16'(nSmp - s0), 16'h000A);
    check(16'(nRise - r0), 16'h0014);
    check(16'(nDac - d0), 16'h0014);
    txSleep <= 1'b1;
    repeat (10) @(posedge clk_sys);
    mark();
    repeat (64) @(posedge clk_sys);
    check(16'(nDac - d0 + nRise - r0), 16'h0000);
    check({15'h0000, cOut}, 16'h0000);
    check(16'(nSmp - s0), 16'h0004);
    rxSleep <= 1'b1;
    repeat (10) @(posedge clk_sys);
    mark();
    repeat (64) @(posedge clk_sys);
    check(16'(nSmp - s0), 16'h0000);
    rxSleep <= 1'b0;
    txSleep <= 1'b0;
    rxChk <= 1'b0;
    wr(fcd_pkg::ADDR_CTRL, 16'h0001);
    repeat (10) @(posedge clk_sys);
    mark();
    repeat (20) @(posedge clk_sys);
    check(16'(nTgl - t0), 16'h0014);
    check({14'h0, interp}, 16'h0001);
    // serial modes, receive direction then transmit direction
    for (int m = 1; m < 4; m++) begin
      txChk <= 1'b0;
      fdMark <= 1'b0;
      dirTx <= 1'b0;
      wr(fcd_pkg::ADDR_CTRL, 16'h0009 | 16'(m << 1));
      repeat (40) @(posedge clk_sys);
      check({6'h0, upOeN}, (m == 1) ? 16'h01FF : 16'h0000);
      check({6'h0, loOeN}, 16'h0000);
      if (m != 1) check({6'h00, loOut}, {6'h00, adcA});
      if (m != 1) check({6'h00, upOut}, {6'h00, adcB});
      rdChk(fcd_pkg::ADDR_STATUS, 16'h0003, 16'(m));
      dirTx <= 1'b1;
      repeat (12) @(posedge clk_sys);
      txChk <= 1'b1;
      wide <= (m == 2);
      mark();
      repeat (40) @(posedge clk_sys);
      check({6'h00, upOeN}, 16'h03FF);
      check({6'h00, loOeN}, 16'h03FF);
      check(16'(nSmp - s0), 16'h0000);
    end
    conclude();
  end
endmodule
